// ### alq_consts.svh
`ifndef ALQ_CONSTS_SVH
`define ALQ_CONSTS_SVH

// ----------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------
`define NCH        8
`define CH_W       3
`define RD_W       32
`define TS_W       32
`define Q_DEPTH    20
`define Q_W        5
`define MEM_DEPTH  50000
`define MEM_W      16
`define ANUM_W     2
`define NUM_W      3
`define NUM_ALARMS 4

// ----------------------------------------------------------------------
// counts and values
// ----------------------------------------------------------------------
`define Q_FULL     5'h0014
`define Q_ONE      5'h0001
`define MEM_FULL   16'hC350
`define MEM_ONE    16'h0001
`define NUM_OFS    3'h1
`define LIMIT_DFLT 32'h0000_0000

`endif

// ### alq_pkg.sv
`include "alq_consts.svh"

package alq_pkg;

  // crossed-limit code: none, lower, upper in that order
  typedef enum logic [1:0] {CROSS_NONE, CROSS_LOWER, CROSS_UPPER} cross_t;

  typedef struct packed {
    logic [`RD_W-1:0]   upper;
    logic [`RD_W-1:0]   lower;
    logic               hi_en;
    logic               lo_en;
    logic [`ANUM_W-1:0] sel;
  } limits_t;

  typedef struct packed {
    limits_t cfg;
    limits_t act;
    logic    member;
    cross_t  prev;
  } chan_t;

  typedef struct packed {
    logic [`RD_W-1:0]  reading;
    logic [`TS_W-1:0]  date;
    logic [`TS_W-1:0]  tod;
    logic [`CH_W-1:0]  chan;
    cross_t            code;
    logic [`NUM_W-1:0] num;
  } qentry_t;

  typedef struct packed {
    logic [`RD_W-1:0] reading;
    cross_t           tag;
  } memword_t;

  typedef struct packed {
    chan_t   [`NCH-1:0]         ch;
    qentry_t [`Q_DEPTH-1:0]     q;
    logic    [`Q_W-1:0]         q_head;
    logic    [`Q_W-1:0]         q_count;
    logic                       q_full;
    logic                       q_valid;
    qentry_t                    q_out;
    logic    [`MEM_W-1:0]       mem_count;
    logic                       mem_valid;
    memword_t                   mem_out;
    logic                       sweep;
    logic    [`NUM_ALARMS-1:0]  status;
    logic                       srq;
  } state_t;

endpackage

// ### alarm_limit_queue.sv
// Function
// - each channel holds one alarm number; many channels may share one
// - queue entries hold reading, absolute date, time of day and channel
// - measurement change or meter disable turns alarms off and clears limits
// - enabling scaling on a channel with limits clears them and disables alarms
// - off-list channel is not evaluated but keeps limits; re-adding restores them
// - scan start empties reading memory of the previous scan
// - queue entry only on a new crossing, not while outside or returning
// - a logged alarm can start a scan sweep internally
// - alarms set status bits that may raise a service request
// - limits default to zero; host keeps lower not above upper
// - factory reset clears all limits and disables all alarms
// - preset and card reset leave limits and enables alone
// - limit edits take effect only once the menu is left
// - upper and lower comparisons are enabled independently
// - unassigned channel reports on alarm number one
// - reading memory holds 50000 readings, readable anytime, reads are not destructive
// - queue holds 20 entries; when full new events are dropped
// - queue emptied by clear status, power cycle, or reading all entries
// - each queue read returns and removes the oldest entry
// - queue read while empty returns zero in every field
// - entry carries crossed-limit code 0 none, 1 lower, 2 upper
// - entry carries alarm number one to four
// - full queue does not stop alarm tagging in reading memory
`timescale 1ns/1ps
`include "alq_consts.svh"

module alarm_limit_queue (
  input  wire logic                   I_MCLK,
  input  wire logic                   I_RST_N,
  input  wire logic                   I_CE,
  input  wire logic [`CH_W-1:0]       I_CFG_CHAN,
  input  wire logic                   I_LIMIT_WE,
  input  wire logic [`RD_W-1:0]       I_UPPER,
  input  wire logic [`RD_W-1:0]       I_LOWER,
  input  wire logic                   I_UPPER_EN,
  input  wire logic                   I_LOWER_EN,
  input  wire logic                   I_ALARM_SEL_WE,
  input  wire logic [`ANUM_W-1:0]     I_ALARM_SEL,
  input  wire logic                   I_MEAS_CFG_CHANGE,
  input  wire logic                   I_SCALE_ENABLE,
  input  wire logic                   I_SCAN_LIST_WE,
  input  wire logic                   I_SCAN_MEMBER,
  input  wire logic                   I_METER_DISABLE,
  input  wire logic                   I_FACTORY_RESET,
  input  wire logic                   I_MENU_ACTIVE,
  input  wire logic                   I_CLEAR_STATUS,
  input  wire logic                   I_SCAN_START,
  input  wire logic                   I_SCANNING,
  input  wire logic                   I_READING_VALID,
  input  wire logic [`CH_W-1:0]       I_READING_CHAN,
  input  wire logic [`RD_W-1:0]       I_READING,
  input  wire logic [`TS_W-1:0]       I_DATE,
  input  wire logic [`TS_W-1:0]       I_TIME,
  input  wire logic                   I_SWEEP_ON_ALARM,
  input  wire logic [`NUM_ALARMS-1:0] I_SRQ_ENABLE,
  input  wire logic                   I_QUEUE_POP,
  input  wire logic                   I_MEM_RD,
  input  wire logic [`MEM_W-1:0]      I_MEM_ADDR,
  output logic                        O_Q_VALID,
  output logic      [`RD_W-1:0]       O_Q_READING,
  output logic      [`TS_W-1:0]       O_Q_DATE,
  output logic      [`TS_W-1:0]       O_Q_TIME,
  output logic      [`CH_W-1:0]       O_Q_CHAN,
  output logic      [1:0]             O_Q_CROSS,
  output logic      [`NUM_W-1:0]      O_Q_ALARM_NUM,
  output logic      [`Q_W-1:0]        O_Q_COUNT,
  output logic                        O_Q_FULL,
  output logic                        O_MEM_VALID,
  output logic      [`RD_W-1:0]       O_MEM_READING,
  output logic      [1:0]             O_MEM_TAG,
  output logic      [`MEM_W-1:0]      O_MEM_COUNT,
  output logic                        O_SWEEP_TRIG,
  output logic      [`NUM_ALARMS-1:0] O_ALARM_STATUS,
  output logic                        O_SRQ
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  alq_pkg::state_t   st;
  alq_pkg::state_t   next_st;
  alq_pkg::memword_t mem [0:`MEM_DEPTH-1];
  alq_pkg::chan_t    rch;
  alq_pkg::cross_t   cur;
  logic              ev;
  logic              mem_we;
  logic [`MEM_W-1:0] mem_waddr;
  alq_pkg::memword_t mem_wdata;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // ring index add, wraps at the queue depth
  function automatic logic [`Q_W-1:0] qadd(input logic [`Q_W-1:0] a, input logic [`Q_W-1:0] b);
    logic [`Q_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, `Q_FULL})
      s = s - {1'b0, `Q_FULL};
    return s[`Q_W-1:0];
  endfunction

  // alarms off and limits back to default; the alarm number stays bound
  function automatic alq_pkg::limits_t cleared(input alq_pkg::limits_t l);
    alq_pkg::limits_t r;
    r       = l;
    r.upper = `LIMIT_DFLT;
    r.lower = `LIMIT_DFLT;
    r.hi_en = 1'b0;
    r.lo_en = 1'b0;
    return r;
  endfunction

  function automatic logic has_limits(input alq_pkg::limits_t l);
    return l.hi_en || l.lo_en || (l.upper != `LIMIT_DFLT) || (l.lower != `LIMIT_DFLT);
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_st           = st;
    next_st.q_valid   = 1'b0;
    next_st.mem_valid = 1'b0;
    rch               = st.ch[I_READING_CHAN];
    cur               = alq_pkg::CROSS_NONE;
    ev                = 1'b0;
    mem_we            = 1'b0;
    mem_waddr         = st.mem_count;
    mem_wdata         = '0;

    // limit evaluation, only for channels on the scan list
    if (I_READING_VALID && rch.member)
    begin
      if (rch.act.hi_en && ($signed(I_READING) > $signed(rch.act.upper)))
        cur = alq_pkg::CROSS_UPPER;
      else if (rch.act.lo_en && ($signed(I_READING) < $signed(rch.act.lower)))
        cur = alq_pkg::CROSS_LOWER;
      ev = (cur != alq_pkg::CROSS_NONE) && (cur != rch.prev);
      next_st.ch[I_READING_CHAN].prev = cur;
    end

    // reading memory keeps only the current scan
    if (I_SCAN_START)
      next_st.mem_count = '0;
    if (I_READING_VALID && I_SCANNING && (next_st.mem_count < `MEM_FULL))
    begin
      mem_we            = 1'b1;
      mem_waddr         = next_st.mem_count;
      mem_wdata.reading = I_READING;
      mem_wdata.tag     = cur;
      next_st.mem_count = next_st.mem_count + `MEM_ONE;
    end
    if (I_MEM_RD)
    begin
      next_st.mem_valid = 1'b1;
      next_st.mem_out   = (I_MEM_ADDR < st.mem_count) ? mem[I_MEM_ADDR] : '0;
    end

    // alarm queue: clear, then pop, then push
    if (I_CLEAR_STATUS)
    begin
      next_st.q_count = '0;
      next_st.q_head  = '0;
    end
    if (I_QUEUE_POP)
    begin
      next_st.q_valid = 1'b1;
      if (next_st.q_count != '0)
      begin
        next_st.q_out   = next_st.q[next_st.q_head];
        next_st.q_head  = qadd(next_st.q_head, `Q_ONE);
        next_st.q_count = next_st.q_count - `Q_ONE;
      end
      else
        next_st.q_out = '0;
    end
    if (ev && (next_st.q_count < `Q_FULL))
    begin
      next_st.q[qadd(next_st.q_head, next_st.q_count)] = '{
        reading: I_READING,
        date:    I_DATE,
        tod:     I_TIME,
        chan:    I_READING_CHAN,
        code:    cur,
        num:     {1'b0, rch.act.sel} + `NUM_OFS};
      next_st.q_count = next_st.q_count + `Q_ONE;
    end
    next_st.q_full = (next_st.q_count == `Q_FULL);

    // status summary; a new alarm outlives a clear in the same cycle
    if (I_CLEAR_STATUS)
      next_st.status = '0;
    if (ev)
      next_st.status[rch.act.sel] = 1'b1;
    next_st.srq   = |(next_st.status & I_SRQ_ENABLE);
    next_st.sweep = ev && I_SWEEP_ON_ALARM;

    // configuration; applied after evaluation so a clear also drops the crossing history
    if (I_LIMIT_WE)
    begin
      next_st.ch[I_CFG_CHAN].cfg.upper = I_UPPER;
      next_st.ch[I_CFG_CHAN].cfg.lower = I_LOWER;
      next_st.ch[I_CFG_CHAN].cfg.hi_en = I_UPPER_EN;
      next_st.ch[I_CFG_CHAN].cfg.lo_en = I_LOWER_EN;
    end
    if (I_ALARM_SEL_WE)
      next_st.ch[I_CFG_CHAN].cfg.sel = I_ALARM_SEL;
    if (I_SCAN_LIST_WE)
      next_st.ch[I_CFG_CHAN].member = I_SCAN_MEMBER;
    if (I_MEAS_CFG_CHANGE || (I_SCALE_ENABLE && has_limits(next_st.ch[I_CFG_CHAN].cfg)))
    begin
      next_st.ch[I_CFG_CHAN].cfg  = cleared(next_st.ch[I_CFG_CHAN].cfg);
      next_st.ch[I_CFG_CHAN].act  = cleared(next_st.ch[I_CFG_CHAN].act);
      next_st.ch[I_CFG_CHAN].prev = alq_pkg::CROSS_NONE;
    end
    for (int i = 0; i < `NCH; i++)
    begin
      // preset and card power-on reset have no input here, so limits and enables survive them
      if (I_METER_DISABLE || I_FACTORY_RESET)
      begin
        next_st.ch[i].cfg  = cleared(next_st.ch[i].cfg);
        next_st.ch[i].act  = cleared(next_st.ch[i].act);
        next_st.ch[i].prev = alq_pkg::CROSS_NONE;
      end
      // edits stay in the shadow set while the menu is open
      if (!I_MENU_ACTIVE)
        next_st.ch[i].act = next_st.ch[i].cfg;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // all-zero reset: limits 0, alarms off, alarm number 1, queue empty
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      st <= '0;
    else if (I_CE)
      st <= next_st;
  end

  // no reset on the reading store; the count alone marks what is valid
  always_ff @(posedge I_MCLK)
  begin
    if (I_CE && mem_we)
      mem[mem_waddr] <= mem_wdata;
  end

  assign O_Q_VALID      = st.q_valid;
  assign O_Q_READING    = st.q_out.reading;
  assign O_Q_DATE       = st.q_out.date;
  assign O_Q_TIME       = st.q_out.tod;
  assign O_Q_CHAN       = st.q_out.chan;
  assign O_Q_CROSS      = st.q_out.code;
  assign O_Q_ALARM_NUM  = st.q_out.num;
  assign O_Q_COUNT      = st.q_count;
  assign O_Q_FULL       = st.q_full;
  assign O_MEM_VALID    = st.mem_valid;
  assign O_MEM_READING  = st.mem_out.reading;
  assign O_MEM_TAG      = st.mem_out.tag;
  assign O_MEM_COUNT    = st.mem_count;
  assign O_SWEEP_TRIG   = st.sweep;
  assign O_ALARM_STATUS = st.status;
  assign O_SRQ          = st.srq;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  logic cfg_touch;
  logic any_en;
  logic [`NCH-1:0] act_en;

  always_comb
  begin
    any_en = 1'b0;
    act_en = '0;
    for (int i = 0; i < `NCH; i++)
    begin
      any_en    = any_en | st.ch[i].cfg.hi_en | st.ch[i].cfg.lo_en;
      act_en[i] = st.ch[i].act.hi_en | st.ch[i].act.lo_en;
    end
  end

  assign cfg_touch = I_LIMIT_WE | I_ALARM_SEL_WE | I_MEAS_CFG_CHANGE | I_SCALE_ENABLE
                   | I_SCAN_LIST_WE | I_METER_DISABLE | I_FACTORY_RESET | I_MENU_ACTIVE;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  property p_empty_pop_zero;
    (I_CE && I_QUEUE_POP && !ev && (st.q_count == '0)) |=>
      O_Q_VALID && (O_Q_READING == '0) && (O_Q_CROSS == '0) && (O_Q_ALARM_NUM == '0) && (O_Q_CHAN == '0);
  endproperty
  a_empty_pop_zero: assert property (p_empty_pop_zero) else $error("empty pop gave nonzero entry");

  property p_pop_fields;
    (I_CE && I_QUEUE_POP && !I_CLEAR_STATUS && (st.q_count != '0)) |=>
      (O_Q_ALARM_NUM >= 3'h1) && (O_Q_ALARM_NUM <= 3'h4) && (O_Q_CROSS != 2'h0) && (O_Q_CROSS != 2'h3);
  endproperty
  a_pop_fields: assert property (p_pop_fields) else $error("popped entry has bad code or number");

  property p_full_drop;
    (I_CE && st.q_full && !I_QUEUE_POP && !I_CLEAR_STATUS) |=> O_Q_FULL && (O_Q_COUNT == `Q_FULL);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("full queue accepted an entry");

  property p_pop_push;
    (I_CE && I_QUEUE_POP && ev && !I_CLEAR_STATUS && (st.q_count != '0)) |=> $stable(O_Q_COUNT);
  endproperty
  a_pop_push: assert property (p_pop_push) else $error("pop with push changed the count");

  property p_clear_status;
    (I_CE && I_CLEAR_STATUS && !ev) |=> (O_Q_COUNT == '0) && (O_ALARM_STATUS == '0) && !O_SRQ;
  endproperty
  a_clear_status: assert property (p_clear_status) else $error("clear status left queue or status");

  property p_scan_start;
    (I_CE && I_SCAN_START && !(I_READING_VALID && I_SCANNING)) |=> (O_MEM_COUNT == '0);
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("scan start kept old readings");

  property p_mem_read_keeps;
    (I_CE && I_MEM_RD && !I_SCAN_START && !I_READING_VALID) |=> $stable(O_MEM_COUNT) && O_MEM_VALID;
  endproperty
  a_mem_read_keeps: assert property (p_mem_read_keeps) else $error("memory read changed contents");

  property p_sweep;
    (I_CE && ev && I_SWEEP_ON_ALARM) |=> O_SWEEP_TRIG ##1 (!O_SWEEP_TRIG || $past(ev || !I_CE));
  endproperty
  a_sweep: assert property (p_sweep) else $error("alarm did not start one sweep");

  property p_status_sticky;
    !(I_CE && I_CLEAR_STATUS) |=> ((O_ALARM_STATUS & $past(O_ALARM_STATUS)) == $past(O_ALARM_STATUS));
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("alarm status bit lost");

  sequence s_logged;
    I_CE && ev && !cfg_touch;
  endsequence
  sequence s_same_again;
    I_CE && I_READING_VALID && !cfg_touch && (I_READING_CHAN == $past(I_READING_CHAN))
      && (I_READING == $past(I_READING)) && $stable(rch.act);
  endsequence
  property p_no_repeat;
    s_logged ##1 s_same_again |-> !ev;
  endproperty
  a_no_repeat: assert property (p_no_repeat) else $error("alarm logged twice while outside");

  property p_factory;
    (I_CE && I_FACTORY_RESET && !I_LIMIT_WE) |=> !any_en && (act_en == '0);
  endproperty
  a_factory: assert property (p_factory) else $error("factory reset left alarms on");

  property p_menu_hold;
    (I_CE && I_MENU_ACTIVE && !I_METER_DISABLE && !I_FACTORY_RESET && !I_MEAS_CFG_CHANGE && !I_SCALE_ENABLE)
      |=> $stable(act_en);
  endproperty
  a_menu_hold: assert property (p_menu_hold) else $error("limits applied while menu open");

endmodule

// ### tb_top.sv
`timescale 1ns/1ps
`include "alq_consts.svh"

module tb_top;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic                   I_MCLK, I_RST_N, I_CE, I_LIMIT_WE, I_UPPER_EN, I_LOWER_EN, I_ALARM_SEL_WE;
  logic                   I_MEAS_CFG_CHANGE, I_SCALE_ENABLE, I_SCAN_LIST_WE, I_SCAN_MEMBER, I_METER_DISABLE;
  logic                   I_FACTORY_RESET, I_MENU_ACTIVE, I_CLEAR_STATUS, I_SCAN_START, I_SCANNING;
  logic                   I_READING_VALID, I_SWEEP_ON_ALARM, I_QUEUE_POP, I_MEM_RD;
  logic [`CH_W-1:0]       I_CFG_CHAN, I_READING_CHAN, O_Q_CHAN;
  logic [`RD_W-1:0]       I_UPPER, I_LOWER, I_READING, O_Q_READING, O_MEM_READING;
  logic [`TS_W-1:0]       I_DATE, I_TIME, O_Q_DATE, O_Q_TIME, stamp;
  logic [`ANUM_W-1:0]     I_ALARM_SEL;
  logic [`NUM_ALARMS-1:0] I_SRQ_ENABLE, O_ALARM_STATUS;
  logic [`MEM_W-1:0]      I_MEM_ADDR, O_MEM_COUNT;
  logic [1:0]             O_Q_CROSS, O_MEM_TAG;
  logic [`NUM_W-1:0]      O_Q_ALARM_NUM;
  logic [`Q_W-1:0]        O_Q_COUNT;
  logic                   O_Q_VALID, O_Q_FULL, O_MEM_VALID, O_SWEEP_TRIG, O_SRQ;
  int                     failures, checks;
  logic [`NUM_W-1:0]      anum [`NCH];
  alq_pkg::qentry_t       expq [$];
  localparam alq_pkg::cross_t xn = alq_pkg::CROSS_NONE;
  localparam alq_pkg::cross_t xl = alq_pkg::CROSS_LOWER;
  localparam alq_pkg::cross_t xu = alq_pkg::CROSS_UPPER;

  alarm_limit_queue u_alarm_limit_queue (
    .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_CFG_CHAN(I_CFG_CHAN), .I_LIMIT_WE(I_LIMIT_WE),
    .I_UPPER(I_UPPER), .I_LOWER(I_LOWER), .I_UPPER_EN(I_UPPER_EN), .I_LOWER_EN(I_LOWER_EN),
    .I_ALARM_SEL_WE(I_ALARM_SEL_WE), .I_ALARM_SEL(I_ALARM_SEL), .I_MEAS_CFG_CHANGE(I_MEAS_CFG_CHANGE),
    .I_SCALE_ENABLE(I_SCALE_ENABLE), .I_SCAN_LIST_WE(I_SCAN_LIST_WE), .I_SCAN_MEMBER(I_SCAN_MEMBER),
    .I_METER_DISABLE(I_METER_DISABLE), .I_FACTORY_RESET(I_FACTORY_RESET), .I_MENU_ACTIVE(I_MENU_ACTIVE),
    .I_CLEAR_STATUS(I_CLEAR_STATUS), .I_SCAN_START(I_SCAN_START), .I_SCANNING(I_SCANNING),
    .I_READING_VALID(I_READING_VALID), .I_READING_CHAN(I_READING_CHAN), .I_READING(I_READING),
    .I_DATE(I_DATE), .I_TIME(I_TIME), .I_SWEEP_ON_ALARM(I_SWEEP_ON_ALARM), .I_SRQ_ENABLE(I_SRQ_ENABLE),
    .I_QUEUE_POP(I_QUEUE_POP), .I_MEM_RD(I_MEM_RD), .I_MEM_ADDR(I_MEM_ADDR), .O_Q_VALID(O_Q_VALID),
    .O_Q_READING(O_Q_READING), .O_Q_DATE(O_Q_DATE), .O_Q_TIME(O_Q_TIME), .O_Q_CHAN(O_Q_CHAN),
    .O_Q_CROSS(O_Q_CROSS), .O_Q_ALARM_NUM(O_Q_ALARM_NUM), .O_Q_COUNT(O_Q_COUNT), .O_Q_FULL(O_Q_FULL),
    .O_MEM_VALID(O_MEM_VALID), .O_MEM_READING(O_MEM_READING), .O_MEM_TAG(O_MEM_TAG),
    .O_MEM_COUNT(O_MEM_COUNT), .O_SWEEP_TRIG(O_SWEEP_TRIG), .O_ALARM_STATUS(O_ALARM_STATUS), .O_SRQ(O_SRQ)
  );

  initial
  begin
    I_MCLK = 1'b0;
    forever #2.5 I_MCLK = ~I_MCLK;
  end

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // k: 0 limits, 1 alarm number, 2 list, 3 measure change, 4 scale, 5 meter off, 6 factory, 7 clear, 8 scan
  task automatic strobe(input int k, input logic [`CH_W-1:0] ch);
    @(posedge I_MCLK);
    I_CFG_CHAN <= ch;
    case (k)
      0: I_LIMIT_WE <= 1'b1;
      1: I_ALARM_SEL_WE <= 1'b1;
      2: I_SCAN_LIST_WE <= 1'b1;
      3: I_MEAS_CFG_CHANGE <= 1'b1;
      4: I_SCALE_ENABLE <= 1'b1;
      5: I_METER_DISABLE <= 1'b1;
      6: I_FACTORY_RESET <= 1'b1;
      7: I_CLEAR_STATUS <= 1'b1;
      default: I_SCAN_START <= 1'b1;
    endcase
    @(posedge I_MCLK);
    {I_LIMIT_WE, I_ALARM_SEL_WE, I_SCAN_LIST_WE, I_MEAS_CFG_CHANGE, I_SCALE_ENABLE, I_METER_DISABLE,
     I_FACTORY_RESET, I_CLEAR_STATUS, I_SCAN_START} <= 9'h000;
    #1;
  endtask

  task automatic lim(input logic [`CH_W-1:0] ch, input logic [`RD_W-1:0] up, lo, input logic ue, le);
    @(posedge I_MCLK);
    I_UPPER <= up;
    I_LOWER <= lo;
    I_UPPER_EN <= ue;
    I_LOWER_EN <= le;
    strobe(0, ch);
  endtask

  task automatic sel(input logic [`CH_W-1:0] ch, input logic [`NUM_W-1:0] n);
    @(posedge I_MCLK);
    I_ALARM_SEL <= 2'(n - 3'h1);
    anum[ch] = n;
    strobe(1, ch);
  endtask

  task automatic member(input logic [`CH_W-1:0] ch, input logic m);
    @(posedge I_MCLK);
    I_SCAN_MEMBER <= m;
    strobe(2, ch);
  endtask

  // c is the crossing this reading should log; the model drops it when 20 are held
  // twice holds the reading for a second back to back cycle, which must log nothing new
  task automatic rd(input logic [`CH_W-1:0] ch, input logic [`RD_W-1:0] v, input alq_pkg::cross_t c,
                    input bit twice = 1'b0);
    alq_pkg::qentry_t e;
    stamp = stamp + 32'h0000_0001;
    e = '{v, stamp, ~stamp, ch, c, anum[ch]};
    if (c != xn && expq.size() < `Q_DEPTH)
      expq.push_back(e);
    @(posedge I_MCLK);
    I_READING_VALID <= 1'b1;
    I_READING_CHAN <= ch;
    I_READING <= v;
    I_DATE <= stamp;
    I_TIME <= ~stamp;
    @(posedge I_MCLK);
    if (twice)
      @(posedge I_MCLK);
    I_READING_VALID <= 1'b0;
    #1;
    chk(O_Q_COUNT, expq.size());
    chk(O_Q_FULL, expq.size() == `Q_DEPTH);
  endtask

  task automatic mrd(input logic [`MEM_W-1:0] a, input logic [`RD_W-1:0] v, input logic [1:0] t);
    @(posedge I_MCLK);
    I_MEM_RD <= 1'b1;
    I_MEM_ADDR <= a;
    @(posedge I_MCLK);
    I_MEM_RD <= 1'b0;
    #1;
    chk(O_MEM_VALID, 1'b1);
    chk({O_MEM_READING, O_MEM_TAG}, {v, t});
  endtask

  task automatic pop();
    alq_pkg::qentry_t e;
    e = '0;
    if (expq.size() > 0)
      e = expq.pop_front();
    @(posedge I_MCLK);
    I_QUEUE_POP <= 1'b1;
    @(posedge I_MCLK);
    I_QUEUE_POP <= 1'b0;
    #1;
    chk(O_Q_VALID, 1'b1);
    chk({O_Q_READING, O_Q_DATE, O_Q_TIME, O_Q_CHAN, O_Q_CROSS, O_Q_ALARM_NUM}, e);
    chk(O_Q_COUNT, expq.size());
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (100000) @(posedge I_MCLK);
    failures++;
    $display("run limit reached");
    give_verdict();
  end

  initial
  begin
    {I_RST_N, I_LIMIT_WE, I_UPPER_EN, I_LOWER_EN, I_ALARM_SEL_WE, I_MEAS_CFG_CHANGE, I_SCALE_ENABLE} = '0;
    {I_SCAN_LIST_WE, I_SCAN_MEMBER, I_METER_DISABLE, I_FACTORY_RESET, I_MENU_ACTIVE, I_CLEAR_STATUS} = '0;
    {I_SCAN_START, I_SCANNING, I_READING_VALID, I_SWEEP_ON_ALARM, I_QUEUE_POP, I_MEM_RD} = '0;
    {I_CFG_CHAN, I_READING_CHAN, I_UPPER, I_LOWER, I_READING, I_DATE, I_TIME} = '0;
    {I_ALARM_SEL, I_SRQ_ENABLE, I_MEM_ADDR, stamp} = '0;
    I_CE = 1'b1;
    failures = 0;
    checks = 0;
    foreach (anum[i]) anum[i] = 3'h1;
    repeat (12) @(posedge I_MCLK);
    I_RST_N <= 1'b1;
    @(posedge I_MCLK);
    #1;
    chk({O_Q_VALID, O_Q_COUNT, O_ALARM_STATUS, O_SRQ, O_MEM_COUNT}, '0);
    pop();
    $display("test empty pop done");

    @(posedge I_MCLK);
    I_SCANNING <= 1'b1;
    I_SWEEP_ON_ALARM <= 1'b1;
    I_SRQ_ENABLE <= 4'h4;
    strobe(8, 3'h0);
    lim(3'h2, 32'h0000_0064, 32'hFFFF_FF9C, 1'b1, 1'b1);
    sel(3'h2, 3'h3);
    member(3'h2, 1'b1);
    rd(3'h2, 32'h0000_00C8, xu);
    chk(O_SWEEP_TRIG, 1'b1);
    chk(O_ALARM_STATUS, 4'h4);
    chk(O_SRQ, 1'b1);
    rd(3'h2, 32'h0000_012C, xn);
    chk(O_SWEEP_TRIG, 1'b0);
    rd(3'h2, 32'h0000_0000, xn);
    rd(3'h2, 32'hFFFF_FF38, xl);
    rd(3'h2, 32'hFFFF_FED4, xn);
    chk(O_MEM_COUNT, 16'h0005);
    mrd(16'h0000, 32'h0000_00C8, xu);
    mrd(16'h0000, 32'h0000_00C8, xu);
    mrd(16'h0003, 32'hFFFF_FF38, xl);
    mrd(16'h0005, 32'h0000_0000, xn);
    pop();
    pop();
    pop();
    $display("test crossing and readout done");

    lim(3'h1, 32'h0000_0032, 32'h0000_0000, 1'b1, 1'b0);
    member(3'h1, 1'b1);
    rd(3'h1, 32'hFFFF_FE0C, xn);
    rd(3'h1, 32'h0000_003C, xu);
    sel(3'h1, 3'h4);
    rd(3'h1, 32'h0000_0000, xn);
    rd(3'h1, 32'h0000_003C, xu);
    chk(O_ALARM_STATUS, 4'hD);
    $display("test alarm numbers done");

    // 20 pairs give 20 crossings; the last two must be dropped
    for (int i = 0; i < 20; i++)
    begin
      rd(3'h1, 32'h0000_0000, xn);
      rd(3'h1, 32'h0000_003C, xu);
    end
    chk(O_MEM_COUNT, 16'h0031);
    mrd(16'h0030, 32'h0000_003C, xu);
    pop();
    strobe(7, 3'h0);
    expq.delete();
    chk({O_Q_COUNT, O_ALARM_STATUS, O_SRQ}, '0);
    $display("test full queue done");

    @(posedge I_MCLK);
    I_MENU_ACTIVE <= 1'b1;
    lim(3'h1, 32'h0000_03E8, 32'h0000_0000, 1'b1, 1'b0);
    rd(3'h1, 32'h0000_0000, xn);
    rd(3'h1, 32'h0000_01F4, xu);
    @(posedge I_MCLK);
    I_MENU_ACTIVE <= 1'b0;
    rd(3'h1, 32'h0000_0000, xn);
    rd(3'h1, 32'h0000_01F4, xn);
    $display("test menu gating done");

    strobe(3, 3'h1);
    rd(3'h1, 32'h0000_1388, xn);
    strobe(4, 3'h2);
    rd(3'h2, 32'h0000_00C8, xn);
    lim(3'h5, 32'h0000_000A, 32'hFFFF_FFF6, 1'b1, 1'b1);
    member(3'h5, 1'b1);
    member(3'h5, 1'b0);
    rd(3'h5, 32'h0000_0064, xn);
    member(3'h5, 1'b1);
    rd(3'h5, 32'h0000_0064, xu, 1'b1);
    strobe(6, 3'h0);
    rd(3'h5, 32'hFFFF_FF9C, xn);
    lim(3'h5, 32'h0000_000A, 32'hFFFF_FFF6, 1'b1, 1'b1);
    member(3'h5, 1'b1);
    rd(3'h5, 32'h0000_0000, xn);
    fork
      pop();
      rd(3'h5, 32'h0000_0064, xu);
    join
    strobe(5, 3'h0);
    rd(3'h5, 32'h0000_0064, xn);
    $display("test clears done");

    // a frozen block must ignore the scan start
    @(posedge I_MCLK);
    I_CE <= 1'b0;
    strobe(8, 3'h0);
    chk(O_MEM_COUNT, 16'h003E);
    @(posedge I_MCLK);
    I_CE <= 1'b1;
    strobe(8, 3'h0);
    chk(O_MEM_COUNT, 16'h0000);
    mrd(16'h0000, 32'h0000_0000, xn);
    $display("test scan restart done");
    give_verdict();
  end
endmodule
